// ---- timer_set_consts.vh ----
// Constants for the three-timer block: register offsets, field positions, reset values, counts.
// Assumes inclusion by bare name from the design files; definitions only.
// Operation
// [R1] Timers 0 and 1 in timer mode step once every 12 clocks while running.
// [R2] Timers 0 and 1 in counter mode step on a falling edge of their pin.
// [R3] Falling-edge detection takes two clocks, so counting is at most half clock rate.
// [R4] The source driving a count pin holds each level at least one clock.
// [R5] Each of Timers 0 and 1 is readable as a high byte and a low byte.
// [R6] Mode 0 counts 13 bits: five low bits of low byte plus high byte.
// [R7] Mode 0 leaves the top three bits of the low byte untouched.
// [R8] Mode 1 counts a full 16 bits across both bytes.
// [R9] Mode 2 is an 8-bit counter reloading itself on overflow.
// [R10] Timer 0 in mode 3 splits into an 8-bit timer/counter and an 8-bit timer.
// [R11] Timer 1 in mode 3 stops and keeps its count.
// [R12] With Timer 0 in mode 3, Timer 1 still counts but sets no flag.
// [R13] Timer 2 has four capture registers and one 16-bit compare/reload register.
// [R14] Timer 2 input select 01 is timer mode, counting from the clock.
// [R15] Timer 2 timer and gated modes step every 12 clocks, or 24 with prescale set.
// [R16] Timer 2 input select 10 counts falling edges of its count pin.
// [R17] Timer 2 pin is sampled each clock; increment follows the detection cycle.
// [R18] Timer 2 input select 11 is gated-timer mode.
// [R19] Gated mode counts like timer mode but halts while the pin is low.
// [R20] Reload mode 0 loads Timer 2 from compare/reload on overflow.
// [R21] Reload mode 1 loads Timer 2 on a falling edge of the reload trigger.
// [R22] The reload trigger is the slow clock divided by two, made internally.
// [R23] Two-bit mode field: 00 13-bit, 01 16-bit, 10 auto-reload, 11 split/stopped.
// [R24] Count source bit: 1 counts pin edges, 0 counts clock ticks.
// [R25] Reload field: upper bit 0 off, 10 reload mode 0, 11 reload mode 1.
// [R26] Clearing a timer's run bit stops that timer.
// [R27] Mode 2 low-byte overflow copies high byte to low byte and sets the flag.
// [R28] Everything resets to zero; each timer flags a rollover from its maximum.
`ifndef TIMER_SET_CONSTS_VH
`define TIMER_SET_CONSTS_VH

`define OFS_TIMER_CONTROL 8'h00
`define OFS_TIMER_MODE 8'h04
`define OFS_CNT0_LOW 8'h08
`define OFS_CNT0_HIGH 8'h0C
`define OFS_CNT1_LOW 8'h10
`define OFS_CNT1_HIGH 8'h14
`define OFS_THIRD_CONTROL 8'h18
`define OFS_CNT2_LOW 8'h1C
`define OFS_CNT2_HIGH 8'h20
`define OFS_COMPARE_RELOAD 8'h24
`define OFS_CAPTURE0 8'h28
`define OFS_CAPTURE1 8'h2C
`define OFS_CAPTURE2 8'h30
`define OFS_CAPTURE3 8'h34
`define OFS_THIRD_STATUS 8'h38

`define TC_OVF1 7
`define TC_RUN1 6
`define TC_OVF0 5
`define TC_RUN0 4
`define TM_GATE1 7
`define TM_SRC1 6
`define TM_MODE1_HI 5
`define TM_MODE1_LO 4
`define TM_GATE0 3
`define TM_SRC0 2
`define TM_MODE0_HI 1
`define TM_MODE0_LO 0
`define T2C_PRESCALE 7
`define T2C_RELOAD_HI 4
`define T2C_RELOAD_LO 3
`define T2C_SEL1 1
`define T2C_SEL0 0
`define T2S_OVF 0

`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000

`define MODE_13BIT 2'b00
`define MODE_16BIT 2'b01
`define MODE_8RELOAD 2'b10
`define MODE_SPLIT 2'b11
`define T2SEL_STOP 2'b00
`define T2SEL_TIMER 2'b01
`define T2SEL_EVENT 2'b10
`define T2SEL_GATED 2'b11
`define RELOAD_ON_OVF 2'b10
`define RELOAD_ON_TRIG 2'b11

`define CLOCKS_PER_TICK 12
`define CLOCKS_PER_SLOW_TICK 24

`endif

// ---- pin_edge.v ----
// Edge detector for a count or clock pin, two sample stages.
// Assumes the pin is already synchronous to pclk.
`timescale 1ns/1ps
module pin_edge (
  input wire pclk,
  input wire presetn,
  input wire pin,
  output wire level,
  output wire rise,
  output wire fall
);
  reg sample_now;
  reg sample_old;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_now <= 1'b0;
      sample_old <= 1'b0;
    end else begin
      sample_now <= pin;
      sample_old <= sample_now;
    end
  end

  // Two samples are needed to see a change, hence half clock rate at most
  assign fall = sample_old & ~sample_now; // [R3]
  assign rise = ~sample_old & sample_now;
  assign level = sample_now;
endmodule

// ---- tick_divider.v ----
// Clock divider giving one-cycle enables every FAST and every 2*FAST clocks.
// Assumes a single free-running clock.
`timescale 1ns/1ps
`include "timer_set_consts.vh"
module tick_divider #(
  parameter FAST = `CLOCKS_PER_TICK
) (
  input wire pclk,
  input wire presetn,
  output wire tick_fast,
  output wire tick_slow
);
  reg [4:0] count;
  reg half;

  assign tick_fast = (count == FAST[4:0] - 5'd1);
  // Slow tick is every second fast tick, so it is always twice the period
  assign tick_slow = tick_fast & half;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 5'd0;
      half <= 1'b0;
    end else if (tick_fast) begin
      count <= 5'd0;
      half <= ~half;
    end else begin
      count <= count + 5'd1;
    end
  end
endmodule

// ---- timer_set.v ----
// Three timer/counters behind an APB slave: Timers 0/1 with four modes, Timer 2 with reload.
// Assumes count, gate and slow-clock pins are synchronous to pclk; one APB master.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "timer_set_consts.vh"
module timer_set (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire timer_zero_input,
  input wire timer_one_input,
  input wire gate_zero_input,
  input wire gate_one_input,
  input wire third_counter_input,
  input wire low_freq_clock
);
  reg [7:0] timer_control_reg;
  reg [7:0] timer_mode_reg;
  reg [7:0] counter0_low_byte;
  reg [7:0] counter0_high_byte;
  reg [7:0] counter1_low_byte;
  reg [7:0] counter1_high_byte;
  reg [7:0] third_timer_control_reg;
  reg [7:0] counter2_low_byte;
  reg [7:0] counter2_high_byte;
  reg [15:0] compare_reload_reg;
  reg [15:0] capture_reg [0:3];
  reg third_overflow_flag;
  reg reload_trigger_input;

  reg [7:0] next_control;
  reg [7:0] next_cnt0_low;
  reg [7:0] next_cnt0_high;
  reg [7:0] next_cnt1_low;
  reg [7:0] next_cnt1_high;
  reg [15:0] next_cnt2;
  reg next_third_ovf;
  reg [16:0] step0;
  reg [16:0] step1;
  reg [8:0] split_low;
  reg [8:0] split_high;
  reg [16:0] cnt2_plus;
  reg [31:0] next_rdata;
  reg next_err;

  wire tick_fast;
  wire tick_slow;
  wire fall_zero;
  wire fall_one;
  wire fall_third;
  wire level_third;
  wire rise_lfclk;
  wire fall_trigger;
  integer k;

  tick_divider #(
    .FAST(`CLOCKS_PER_TICK)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick_fast(tick_fast),
    .tick_slow(tick_slow)
  );

  pin_edge u_edge_zero (
    .pclk(pclk),
    .presetn(presetn),
    .pin(timer_zero_input),
    .level(),
    .rise(),
    .fall(fall_zero)
  );

  pin_edge u_edge_one (
    .pclk(pclk),
    .presetn(presetn),
    .pin(timer_one_input),
    .level(),
    .rise(),
    .fall(fall_one)
  );

  pin_edge u_edge_third (
    .pclk(pclk),
    .presetn(presetn),
    .pin(third_counter_input),
    .level(level_third),
    .rise(),
    .fall(fall_third)
  );

  pin_edge u_edge_lfclk (
    .pclk(pclk),
    .presetn(presetn),
    .pin(low_freq_clock),
    .level(),
    .rise(rise_lfclk),
    .fall()
  );

  pin_edge u_edge_trigger (
    .pclk(pclk),
    .presetn(presetn),
    .pin(reload_trigger_input),
    .level(),
    .rise(),
    .fall(fall_trigger)
  );

  // One count step of Timer 0 or 1 in the given mode: {overflow, high, low}
  function [16:0] step;
    input [1:0] mode;
    input [7:0] lo;
    input [7:0] hi;
    reg [13:0] c13;
    reg [16:0] c16;
    reg [8:0] c8;
    begin
      c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      c16 = {1'b0, hi, lo} + 17'h00001;
      c8 = {1'b0, lo} + 9'h001;
      case (mode)
        `MODE_13BIT: step = {c13[13], c13[12:5], lo[7:5], c13[4:0]}; // [R6] [R7]
        `MODE_16BIT: step = c16; // [R8]
        `MODE_8RELOAD: step = c8[8] ? {1'b1, hi, hi} : {1'b0, hi, c8[7:0]}; // [R9] [R27]
        default: step = {1'b0, hi, lo}; // [R11]
      endcase
    end
  endfunction

  // Plain byte increment with carry, shared by both halves of a split Timer 0
  function [8:0] bump8;
    input [7:0] v;
    begin
      bump8 = {1'b0, v} + 9'h001;
    end
  endfunction

  // Mode fields pick 13-bit, 16-bit, auto-reload, or split/stopped per timer
  wire [1:0] mode0 = timer_mode_reg[`TM_MODE0_HI:`TM_MODE0_LO]; // [R23]
  wire [1:0] mode1 = timer_mode_reg[`TM_MODE1_HI:`TM_MODE1_LO]; // [R23]
  // Run bit stops the timer; gate bit also needs the gate pin high
  wire run0 = timer_control_reg[`TC_RUN0] &
              (~timer_mode_reg[`TM_GATE0] | gate_zero_input); // [R26]
  wire run1 = timer_control_reg[`TC_RUN1] &
              (~timer_mode_reg[`TM_GATE1] | gate_one_input); // [R26]
  wire inc0 = run0 & (timer_mode_reg[`TM_SRC0] ? fall_zero : tick_fast); // [R1] [R2] [R24]
  wire inc1 = run1 & (timer_mode_reg[`TM_SRC1] ? fall_one : tick_fast); // [R1] [R2] [R24]
  // Upper half of a split Timer 0 borrows Timer 1's run bit, clock ticks only
  wire inc0_high = timer_control_reg[`TC_RUN1] & tick_fast; // [R10]

  wire [1:0] t2sel = third_timer_control_reg[`T2C_SEL1:`T2C_SEL0];
  wire [1:0] t2reload = third_timer_control_reg[`T2C_RELOAD_HI:`T2C_RELOAD_LO];
  wire t2tick = third_timer_control_reg[`T2C_PRESCALE] ? tick_slow : tick_fast; // [R15]
  reg inc2;

  // Stopped, clock ticks, pin edges, or clock ticks gated by the pin
  always @* begin
    case (t2sel)
      `T2SEL_TIMER: inc2 = t2tick; // [R14]
      `T2SEL_EVENT: inc2 = fall_third; // [R16] [R17]
      `T2SEL_GATED: inc2 = t2tick & level_third; // [R18] [R19]
      default: inc2 = 1'b0;
    endcase
  end

  // Writes land on the access edge, where the master sees pready high
  wire apb_write = psel & penable & pready & pwrite;
  wire [15:0] cnt2 = {counter2_high_byte, counter2_low_byte};

  // Counting first; a counter-byte write in the same cycle overrides that byte
  always @* begin
    next_control = timer_control_reg;
    next_cnt0_low = counter0_low_byte;
    next_cnt0_high = counter0_high_byte;
    next_cnt1_low = counter1_low_byte;
    next_cnt1_high = counter1_high_byte;
    next_cnt2 = cnt2;
    next_third_ovf = third_overflow_flag;
    step0 = step(mode0, counter0_low_byte, counter0_high_byte);
    step1 = step(mode1, counter1_low_byte, counter1_high_byte);
    split_low = bump8(counter0_low_byte);
    split_high = bump8(counter0_high_byte);
    cnt2_plus = {1'b0, cnt2} + 17'h00001;
    if (apb_write && paddr == `OFS_TIMER_CONTROL) begin
      next_control = pwdata[7:0];
    end
    // Clear first, so a hardware set further down wins in the same cycle
    if (apb_write && paddr == `OFS_THIRD_STATUS && pwdata[`T2S_OVF]) begin
      next_third_ovf = 1'b0;
    end
    if (mode0 == `MODE_SPLIT) begin
      if (inc0) begin
        next_cnt0_low = split_low[7:0]; // [R10]
        if (split_low[8]) begin
          next_control[`TC_OVF0] = 1'b1; // [R10]
        end
      end
      if (inc0_high) begin
        next_cnt0_high = split_high[7:0]; // [R10]
        if (split_high[8]) begin
          next_control[`TC_OVF1] = 1'b1; // [R10]
        end
      end
    end else if (inc0) begin
      next_cnt0_high = step0[15:8];
      next_cnt0_low = step0[7:0];
      if (step0[16]) begin
        next_control[`TC_OVF0] = 1'b1; // [R28]
      end
    end
    if (inc1 && mode1 != `MODE_SPLIT) begin // [R11]
      next_cnt1_high = step1[15:8];
      next_cnt1_low = step1[7:0];
      // Flag belongs to split Timer 0 while it is in mode 3
      if (step1[16] && mode0 != `MODE_SPLIT) begin // [R12]
        next_control[`TC_OVF1] = 1'b1; // [R28]
      end
    end
    // A trigger reload beats an increment landing in the same cycle
    if (t2reload == `RELOAD_ON_TRIG && fall_trigger) begin
      next_cnt2 = compare_reload_reg; // [R21] [R25]
    end else if (inc2) begin
      if (cnt2_plus[16]) begin
        next_third_ovf = 1'b1; // [R28]
        next_cnt2 = (t2reload == `RELOAD_ON_OVF) ? compare_reload_reg : 16'h0000; // [R20] [R25]
      end else begin
        next_cnt2 = cnt2_plus[15:0];
      end
    end
    if (apb_write) begin
      case (paddr)
        `OFS_CNT0_LOW: next_cnt0_low = pwdata[7:0];
        `OFS_CNT0_HIGH: next_cnt0_high = pwdata[7:0];
        `OFS_CNT1_LOW: next_cnt1_low = pwdata[7:0];
        `OFS_CNT1_HIGH: next_cnt1_high = pwdata[7:0];
        `OFS_CNT2_LOW: next_cnt2[7:0] = pwdata[7:0];
        `OFS_CNT2_HIGH: next_cnt2[15:8] = pwdata[7:0];
        default: next_cnt2 = next_cnt2;
      endcase
    end
  end

  // Mode, Timer 2 control and compare registers change only by an APB write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_reg <= `RESET_BYTE; // [R28]
      timer_mode_reg <= `RESET_BYTE;
      counter0_low_byte <= `RESET_BYTE;
      counter0_high_byte <= `RESET_BYTE;
      counter1_low_byte <= `RESET_BYTE;
      counter1_high_byte <= `RESET_BYTE;
      third_timer_control_reg <= `RESET_BYTE;
      counter2_low_byte <= `RESET_BYTE;
      counter2_high_byte <= `RESET_BYTE;
      compare_reload_reg <= `RESET_WORD;
      third_overflow_flag <= 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        capture_reg[k] <= `RESET_WORD;
      end
    end else begin
      timer_control_reg <= next_control;
      counter0_low_byte <= next_cnt0_low; // [R5]
      counter0_high_byte <= next_cnt0_high; // [R5]
      counter1_low_byte <= next_cnt1_low; // [R5]
      counter1_high_byte <= next_cnt1_high; // [R5]
      counter2_low_byte <= next_cnt2[7:0];
      counter2_high_byte <= next_cnt2[15:8];
      third_overflow_flag <= next_third_ovf;
      if (apb_write) begin
        case (paddr)
          `OFS_TIMER_MODE: timer_mode_reg <= pwdata[7:0];
          `OFS_THIRD_CONTROL: third_timer_control_reg <= pwdata[7:0];
          `OFS_COMPARE_RELOAD: compare_reload_reg <= pwdata[15:0]; // [R13]
          // A write to a capture slot snapshots the live count without stopping it
          `OFS_CAPTURE0: capture_reg[0] <= cnt2; // [R13]
          `OFS_CAPTURE1: capture_reg[1] <= cnt2; // [R13]
          `OFS_CAPTURE2: capture_reg[2] <= cnt2; // [R13]
          `OFS_CAPTURE3: capture_reg[3] <= cnt2; // [R13]
          default: timer_mode_reg <= timer_mode_reg;
        endcase
      end
    end
  end

  // Reload trigger toggles on each slow-clock rise, giving half its rate
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_trigger_input <= 1'b0;
    end else if (rise_lfclk) begin
      reload_trigger_input <= ~reload_trigger_input; // [R22]
    end
  end

  // Unmapped offsets read as zero and answer with an error
  always @* begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    case (paddr)
      `OFS_TIMER_CONTROL: next_rdata[7:0] = timer_control_reg;
      `OFS_TIMER_MODE: next_rdata[7:0] = timer_mode_reg;
      `OFS_CNT0_LOW: next_rdata[7:0] = counter0_low_byte;
      `OFS_CNT0_HIGH: next_rdata[7:0] = counter0_high_byte;
      `OFS_CNT1_LOW: next_rdata[7:0] = counter1_low_byte;
      `OFS_CNT1_HIGH: next_rdata[7:0] = counter1_high_byte;
      `OFS_THIRD_CONTROL: next_rdata[7:0] = third_timer_control_reg;
      `OFS_CNT2_LOW: next_rdata[7:0] = counter2_low_byte;
      `OFS_CNT2_HIGH: next_rdata[7:0] = counter2_high_byte;
      `OFS_COMPARE_RELOAD: next_rdata[15:0] = compare_reload_reg;
      `OFS_CAPTURE0: next_rdata[15:0] = capture_reg[0];
      `OFS_CAPTURE1: next_rdata[15:0] = capture_reg[1];
      `OFS_CAPTURE2: next_rdata[15:0] = capture_reg[2];
      `OFS_CAPTURE3: next_rdata[15:0] = capture_reg[3];
      `OFS_THIRD_STATUS: next_rdata[`T2S_OVF] = third_overflow_flag;
      default: next_err = 1'b1;
    endcase
  end

  // No wait state: read data is captured at the end of the setup cycle, so the answer
  // comes from flops while pready is high in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h00000000 : next_rdata;
        pslverr <= next_err;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule

// ---- timer_set_checker.sv ----
// Checker on the APB port of timer_set.
// Assumes one clock and an active-low reset; bound to every timer_set.
`timescale 1ns/1ps
module timer_set_checker (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  wire bad = paddr > 8'h38 || paddr[1:0] != 2'h0;
  a_ready_next: assert property (setup |=> pready && penable)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_unmapped: assert property (setup && bad |=> pslverr)
    else $error("unmapped not refused");
  a_err_mapped: assert property (setup && !bad |=> !pslverr)
    else $error("mapped refused");
  a_byte_read: assert property (
    setup && !pwrite && (paddr < 8'h24 || paddr == 8'h38) |=> prdata[31:8] == 24'h0)
    else $error("byte read wide");
  a_word_read: assert property (
    setup && !pwrite && paddr >= 8'h24 |=> prdata[31:16] == 16'h0)
    else $error("word read wide");
  a_reset_quiet: assert property ($rose(presetn) |-> !pready && prdata == 32'h0)
    else $error("bus busy after reset");
endmodule

bind timer_set timer_set_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr);

// ---- pin_source.sv ----
// Far-side model: count pins and slow clock, sending a burst of n high pulses.
// Assumes pins idle low; slow holds each level two clocks instead of one.
`timescale 1ns/1ps
module pin_source (
  input logic pclk,
  input logic [1:0] sel,
  input logic [7:0] n,
  input logic slow,
  input logic go,
  output logic [3:0] pins,
  output logic busy
);
  logic [8:0] left;
  logic [1:0] hold;
  initial begin
    pins = 4'h0;
    busy = 1'b0;
    left = 9'h000;
    hold = 2'h0;
  end
  always @(posedge pclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      left <= {n, 1'b0};
      hold <= 2'h0;
    end else if (busy) begin
      if (hold != {1'b0, slow}) begin
        hold <= hold + 2'h1;
      end else if (left == 9'h000) begin
        busy <= 1'b0;
      end else begin
        pins[sel] <= ~pins[sel];
        left <= left - 9'h001;
        hold <= 2'h0;
      end
    end
  end
endmodule

// ---- timer_set_tb_top.sv ----
// Self-checking bench for timer_set: APB master, pin source and checker.
// Assumes pins synchronous to pclk; gate pins held low, gate bit set only for Timer 0 in row 7.
`timescale 1ns/1ps
`include "timer_set_consts.vh"
module timer_set_tb_top;
  localparam logic [7:0] CTL = `OFS_TIMER_CONTROL;
  localparam logic [7:0] C2L = `OFS_CNT2_LOW;
  localparam logic [7:0] C2H = `OFS_CNT2_HIGH;
  localparam logic [7:0] T2C = `OFS_THIRD_CONTROL;
  logic pclk, presetn, psel, penable, pwrite, go, slow, e;
  logic [7:0] paddr, num, b;
  logic [31:0] pwdata, q;
  logic [1:0] sel;
  logic [63:0] r;
  logic [63:0] rows [8];
  wire [31:0] prdata;
  wire pready, pslverr, busy;
  wire [3:0] pins;
  int error_cnt, samples_checked;
  timer_set u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer_zero_input(pins[0]), .timer_one_input(pins[1]),
    .gate_zero_input(1'b0), .gate_one_input(1'b0), .third_counter_input(pins[2]),
    .low_freq_clock(pins[3]));
  pin_source u_pins (.pclk, .sel, .n(num), .slow, .go, .pins, .busy);
  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] x);
    samples_checked++;
    if (got !== x) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, x);
    end
  endtask
  // Tick phase is unknown to the bench, so a count may land one either side
  task automatic near(input logic [31:0] got, input logic [31:0] x);
    samples_checked++;
    if (got !== x && got !== x + 1 && got + 1 !== x) begin
      error_cnt++;
      $display("MISMATCH %0t got %h near %h", $time, got, x);
    end
  endtask
  task automatic guard(inout int n);
    n++;
    if (n > 100) begin
      error_cnt++;
      summarize();
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      guard(n);
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic pulse(input logic [1:0] s, input logic [7:0] k, input logic sl);
    int n;
    n = 0;
    sel <= s;
    num <= k;
    slow <= sl;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy !== 1'b0) begin
      guard(n);
      @(posedge pclk);
    end
    // Edge detection needs two clocks before the count moves
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, go, slow} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    num = 8'h00;
    sel = 2'h0;
    // run, mode, low, high, edges, low, high, control after
    rows[0] = 64'h10_05_FE_00_03_01_01_10;
    rows[1] = 64'h10_04_FF_00_02_E1_01_10;
    rows[2] = 64'h10_06_FE_80_03_81_80_30;
    rows[3] = 64'h40_50_FF_FF_01_00_00_C0;
    rows[4] = 64'h40_70_34_12_04_34_12_40;
    rows[5] = 64'h10_07_FE_00_03_01_00_30;
    rows[6] = 64'h40_57_FF_FF_01_00_00_40;
    rows[7] = 64'h10_0D_00_00_02_00_00_10;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a <= 8'h38; a += 4) rd(a[7:0], 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk({31'h0, e}, 32'h1);
    // Row 6 counts Timer 1 beside a split Timer 0; row 7 holds Timer 0 by its gate
    foreach (rows[i]) begin
      r = rows[i];
      b = r[63:56] == 8'h40 ? 8'h10 : 8'h08;
      w(`OFS_TIMER_MODE, {24'h0, r[55:48]});
      w(b, {24'h0, r[47:40]});
      w(b + 8'h04, {24'h0, r[39:32]});
      w(CTL, {24'h0, r[63:56]});
      pulse({1'b0, b[4]}, r[31:24], i[0]);
      rd(CTL, {24'h0, r[7:0]});
      w(CTL, 32'h0);
      rd(b, {24'h0, r[23:16]});
      rd(b + 8'h04, {24'h0, r[15:8]});
    end
    w(`OFS_TIMER_MODE, 32'h01);
    w(8'h08, 32'h0);
    w(CTL, 32'h10);
    repeat (240) @(posedge pclk);
    w(CTL, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    near(q, 32'h14);
    repeat (30) @(posedge pclk);
    rd(8'h08, q);
    for (int p = 0; p < 2; p++) begin
      w(C2L, 32'h0);
      w(T2C, p ? 32'h81 : 32'h01);
      repeat (240) @(posedge pclk);
      w(T2C, 32'h0);
      apb(1'b0, C2L, 32'h0);
      near(q, p ? 32'h0A : 32'h14);
    end
    w(C2L, 32'h0);
    w(T2C, 32'h03);
    repeat (120) @(posedge pclk);
    rd(C2L, 32'h0);
    w(T2C, 32'h02);
    pulse(2'h2, 8'h05, 1'b1);
    rd(C2L, 32'h05);
    w(`OFS_COMPARE_RELOAD, 32'hABCD);
    w(C2L, 32'hFF);
    w(C2H, 32'hFF);
    w(T2C, 32'h12);
    pulse(2'h2, 8'h01, 1'b0);
    rd(C2L, 32'hCD);
    rd(C2H, 32'hAB);
    rd(`OFS_THIRD_STATUS, 32'h01);
    w(`OFS_THIRD_STATUS, 32'h01);
    rd(`OFS_THIRD_STATUS, 32'h00);
    w(T2C, 32'h18);
    w(C2H, 32'h0);
    pulse(2'h3, 8'h01, 1'b0);
    rd(C2H, 32'h0);
    pulse(2'h3, 8'h01, 1'b1);
    rd(C2H, 32'hAB);
    w(`OFS_CAPTURE1, 32'h0);
    rd(`OFS_CAPTURE1, 32'hABCD);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`OFS_COMPARE_RELOAD, 32'h0);
    summarize();
  end
endmodule
